// ==== sdsw_map.vh ====
// Register offsets, field positions, reset values and timing counts of the card-detect and wake block.
`ifndef SDSW_MAP_VH
`define SDSW_MAP_VH
// Register byte offsets on the APB.
`define SDSW_CTRL_OFF      12'h000
`define SDSW_STATUS_OFF    12'h004
`define SDSW_EVENT_OFF     12'h008
`define SDSW_EVCLR_OFF     12'h00C
`define SDSW_EVEN_OFF      12'h010
`define SDSW_REQ_OFF       12'h014
// Control register fields.
`define SDSW_CTRL_HOTPLUG  0
`define SDSW_CTRL_INVERT   1
`define SDSW_CTRL_SMSWAKE  2
`define SDSW_CTRL_RFON     3
`define SDSW_CTRL_RST      4'h1
// Request register fields, write one to pulse.
`define SDSW_REQ_SMS       0
`define SDSW_REQ_DATA      1
`define SDSW_REQ_INITDONE  2
`define SDSW_REQ_REGDONE   3
// Event bits.
`define SDSW_EV_INSERT     0
`define SDSW_EV_REMOVE     1
`define SDSW_EV_WAKE       2
`define SDSW_EV_W          3
// Timing: wake pulse in ms, debounce in us, clock period in ns.
`define SDSW_CLK_NS        10
`define SDSW_WAKE_MS       1000
`define SDSW_WAKE_CYC      ((`SDSW_WAKE_MS * 1000000) / `SDSW_CLK_NS)
`define SDSW_DEB_US        1000
`define SDSW_DEB_CYC       ((`SDSW_DEB_US * 1000) / `SDSW_CLK_NS)
// Synchroniser stages ahead of the debounce filter.
`define SDSW_SYNC_STAGES   2
`endif

// ==== sdsw_debounce.v ====
// Two-flop synchroniser and debounce filter for the card-presence input.
`timescale 1ns/1ps
`default_nettype none
module sdsw_debounce #(
	parameter integer DEB_CYC = 100000
) (
	input  wire pclk,
	input  wire presetn,
	input  wire raw_in,
	output reg  settled_ff
);
	// Synchroniser stages; the first is read only by the second.
	reg        sync1_ff;
	reg        sync2_ff;
	// Stability counter.
	reg [31:0] cnt_ff;

	// Synchronise, then accept a level only after it stayed stable for DEB_CYC cycles.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff   <= 1'b0;
			sync2_ff   <= 1'b0;
			cnt_ff     <= 32'h0000_0000;
			settled_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
			// Any agreement with the settled level restarts the count.
			if (sync2_ff == settled_ff)
				cnt_ff <= 32'h0000_0000;
			else if (cnt_ff >= DEB_CYC - 1)
			begin
				settled_ff <= sync2_ff;
				cnt_ff     <= 32'h0000_0000;
			end
			else
				cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end
endmodule // sdsw_debounce
`default_nettype wire

// ==== sdsw_main.v ====
// Card presence detection, card bring-up sequencing, status LED and host wake pulse with APB registers.
// Functional notes
// (R01) Default polarity: high input means card inserted.
// (R02) Hot-plug detection resets enabled, tracks continuously.
// (R03) Disabled detection samples once at start-up only.
// (R04) Insertion starts init, reads card, requests registration.
// (R05) Absence marks card detached, no card read.
// (R06) Polarity setting makes low mean inserted.
// (R07) LED output low while RF on, high otherwise.
// (R08) Request pulls host wake low one second.
// (R09) SMS wake needs enable set first.
// (R10) Presence input synchronised and debounced before use.
// (R11) Request during pulse neither restarts nor lengthens.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdsw_map.vh"
module sdsw_main #(
	parameter integer WAKE_CYC = `SDSW_WAKE_CYC,
	parameter integer DEB_CYC  = `SDSW_DEB_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        card_present_in,
	output reg         status_led_n,
	output reg         host_wake_n,
	output reg         card_init_start,
	output reg         card_read_start,
	output reg         net_reg_req,
	output reg         irq
);
	// Sequencer states, one-hot.
	localparam [4:0] ST_ABSENT = 5'h01;
	localparam [4:0] ST_INIT   = 5'h02;
	localparam [4:0] ST_READ   = 5'h04;
	localparam [4:0] ST_REG    = 5'h08;
	localparam [4:0] ST_READY  = 5'h10;

	// Control register: hot-plug enable, invert, SMS wake enable, RF on.
	reg  [3:0]  ctrl_ff;
	// Sticky event bits and their enables.
	reg  [2:0]  event_ff;
	reg  [2:0]  even_ff;
	// Debounced raw level from the filter.
	wire        deb_level;
	// Presence as decided, after polarity and hot-plug handling.
	reg         present_ff;
	// Start-up sample taken flag for disabled detection.
	reg         boot_done_ff;
	// Debounce has had time to settle since reset.
	reg  [31:0] boot_cnt_ff;
	// Sequencer state.
	reg  [4:0]  state_ff;
	reg  [4:0]  nxt_state;
	// Wake pulse counter; nonzero while the pulse runs.
	reg  [31:0] wake_cnt_ff;
	// Access-phase decode.
	wire        acc;
	wire        wr;
	wire        rd;
	// Request strobes from software.
	wire [3:0]  req;
	// Polarity-corrected presence and its start-up-gated form.
	wire        pol_level;
	wire        nxt_present;
	// Events this cycle.
	wire [2:0]  ev_set;
	wire        wake_req;
	wire        wake_go;
	// Offset hits of the writable registers.
	wire        hit_ctrl;
	wire        hit_evclr;
	wire        hit_even;
	wire        hit_req;
	// Offsets that take a write; the rest refuse one.
	wire        hit_wrable;
	// Clear strobe per event bit from the clear register.
	wire [2:0]  ev_clr;
	// Start-up sample window has ended.
	wire        boot_end;

	// Synchronise and debounce the presence pin before any logic reads it. [R10]
	sdsw_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
		.pclk       (pclk),
		.presetn    (presetn),
		.raw_in     (card_present_in),
		.settled_ff (deb_level)
	);

	// APB access phase decode; every access finishes in its second access cycle.
	assign acc = psel & penable & ~pready;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;
	// Offset decode; each register owns one aligned word.
	assign hit_ctrl   = (paddr == `SDSW_CTRL_OFF);
	assign hit_evclr  = (paddr == `SDSW_EVCLR_OFF);
	assign hit_even   = (paddr == `SDSW_EVEN_OFF);
	assign hit_req    = (paddr == `SDSW_REQ_OFF);
	// Status and event registers are read-only; unknown offsets refuse writes too.
	assign hit_wrable = hit_ctrl | hit_evclr | hit_even | hit_req;
	// Software strobes last the single write cycle.
	assign req = (wr && hit_req) ? pwdata[3:0] : 4'h0;
	// Writing a one to the clear register clears that event bit.
	assign ev_clr = (wr && hit_evclr) ? pwdata[2:0] : 3'h0;
	// The start-up sample is final once sync and filter have had their full window.
	assign boot_end = (boot_cnt_ff >= DEB_CYC + `SDSW_SYNC_STAGES);

	// High means inserted by default; the invert bit swaps that. [R01] [R06]
	assign pol_level = deb_level ^ ctrl_ff[`SDSW_CTRL_INVERT];
	// Enabled or inside the start-up window: follow; disabled after it: hold the presence last decided. [R02] [R03]
	assign nxt_present = (ctrl_ff[`SDSW_CTRL_HOTPLUG] || !boot_done_ff) ? pol_level : present_ff;

	// SMS needs the wake enable; data requests always wake. [R09]
	assign wake_req = (req[`SDSW_REQ_SMS] & ctrl_ff[`SDSW_CTRL_SMSWAKE]) | req[`SDSW_REQ_DATA];
	// A request during a running pulse is dropped. [R11]
	assign wake_go  = wake_req & (wake_cnt_ff == 32'h0000_0000);

	assign ev_set[`SDSW_EV_INSERT] = nxt_present & ~present_ff;
	assign ev_set[`SDSW_EV_REMOVE] = ~nxt_present & present_ff;
	assign ev_set[`SDSW_EV_WAKE]   = wake_go;

	// APB register writes, read mux and the one-cycle bus answer.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Control comes up with hot-plug detection on and all else off.
			ctrl_ff  <= `SDSW_CTRL_RST;
			even_ff  <= 3'h0;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
		end
		else
		begin
			pready  <= acc;
			pslverr <= 1'b0;
			// Control and enable writes.
			if (wr && hit_ctrl)
				ctrl_ff <= pwdata[3:0];
			if (wr && hit_even)
				even_ff <= pwdata[2:0];
			// Read mux; unmapped addresses answer with an error.
			if (rd)
			begin
				// Status packs the wake flag, the one-hot state and presence.
				case (paddr)
					`SDSW_CTRL_OFF:   prdata <= {28'h000_0000, ctrl_ff};
					`SDSW_STATUS_OFF: prdata <= {25'h000_0000, ~host_wake_n, state_ff, present_ff};
					`SDSW_EVENT_OFF:  prdata <= {29'h0000_0000, event_ff};
					`SDSW_EVEN_OFF:   prdata <= {29'h0000_0000, even_ff};
					`SDSW_EVCLR_OFF:  prdata <= 32'h0000_0000;
					`SDSW_REQ_OFF:    prdata <= 32'h0000_0000;
					default:
					begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
			else if (acc)
			begin
				// Write cycle: no read data is returned.
				prdata <= 32'h0000_0000;
				// A write to a read-only or unknown offset is refused.
				if (!hit_wrable)
					pslverr <= 1'b1;
			end
		end
	end

	// One sticky flag per event bit; hardware sets it, software clears it.
	genvar gi;
	generate
		for (gi = 0; gi < `SDSW_EV_W; gi = gi + 1)
		begin : g_event
			// A fresh event wins over a clear that lands in the same cycle.
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					event_ff[gi] <= 1'b0;
				end
				else if (ev_set[gi])
				begin
					// Hardware set has priority.
					event_ff[gi] <= 1'b1;
				end
				else if (ev_clr[gi])
				begin
					// Software clear by writing a one.
					event_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Presence tracking and the one-time start-up sample.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// The card counts as absent until the filter has settled.
			present_ff   <= 1'b0;
			boot_done_ff <= 1'b0;
			boot_cnt_ff  <= 32'h0000_0000;
		end
		else
		begin
			// Follow the polarity-corrected level, or hold it once frozen.
			present_ff <= nxt_present;
			// Start-up sample is final once the filter has had one full window plus sync delay. [R03]
			if (boot_end)
			begin
				// Freeze the count; the flag stays set until the next reset.
				boot_done_ff <= 1'b1;
			end
			else
			begin
				// Still inside the start-up window.
				boot_cnt_ff <= boot_cnt_ff + 32'h0000_0001;
			end
		end
	end

	// Card sequencer next state.
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_ABSENT:
			begin
				// Insertion starts the initialisation. [R04]
				if (present_ff)
					nxt_state = ST_INIT;
			end
			ST_INIT:
			begin
				// Wait for software to report the card initialised.
				if (!present_ff)
					nxt_state = ST_ABSENT;
				else if (req[`SDSW_REQ_INITDONE])
					nxt_state = ST_READ;
			end
			ST_READ:
			begin
				// Wait for software to report the card information read.
				if (!present_ff)
					nxt_state = ST_ABSENT;
				else if (req[`SDSW_REQ_REGDONE])
					nxt_state = ST_REG;
			end
			ST_REG:
			begin
				// The registration request goes out once, then the card is ready.
				if (!present_ff)
					nxt_state = ST_ABSENT;
				else
					nxt_state = ST_READY;
			end
			ST_READY:
			begin
				// Removal marks the card detached. [R05]
				if (!present_ff)
					nxt_state = ST_ABSENT;
			end
			default:
			begin
				// An illegal code falls back to the idle state.
				nxt_state = ST_ABSENT;
			end
		endcase
	end

	// Sequencer state and its one-cycle command pulses.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Idle, with no command pulse pending.
			state_ff        <= ST_ABSENT;
			card_init_start <= 1'b0;
			card_read_start <= 1'b0;
			net_reg_req     <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			// Init, then card read, then registration, each on state entry. [R04]
			card_init_start <= (nxt_state == ST_INIT) && (state_ff != ST_INIT);
			// No card read is ever issued while absent. [R05]
			card_read_start <= (nxt_state == ST_READ) && (state_ff != ST_READ);
			// Registration request follows the card read.
			net_reg_req     <= (nxt_state == ST_REG) && (state_ff != ST_REG);
		end
	end

	// Status LED, host wake pulse and interrupt line.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// LED dark, wake line released, no interrupt.
			status_led_n <= 1'b1;
			host_wake_n  <= 1'b1;
			wake_cnt_ff  <= 32'h0000_0000;
			irq          <= 1'b0;
		end
		else
		begin
			// LED lit (low) while RF is on. [R07]
			status_led_n <= ~ctrl_ff[`SDSW_CTRL_RFON];
			// Pulse low for exactly WAKE_CYC cycles, high otherwise. [R08] [R11]
			if (wake_go)
			begin
				// Start a fresh pulse only from idle.
				wake_cnt_ff <= WAKE_CYC;
				host_wake_n <= 1'b0;
			end
			else if (wake_cnt_ff > 32'h0000_0001)
			begin
				// Pulse still running; count it down.
				wake_cnt_ff <= wake_cnt_ff - 32'h0000_0001;
			end
			else
			begin
				// Last low cycle or idle: release the line.
				wake_cnt_ff <= 32'h0000_0000;
				host_wake_n <= 1'b1;
			end
			// Interrupt is high while any enabled event is pending.
			irq <= |(event_ff & even_ff);
		end
	end
endmodule // sdsw_main
`default_nettype wire

// ==== sdsw_props.sv ====
// Port-level assertions for the card-detect and wake block.
`timescale 1ns/1ps
`default_nettype none
module sdsw_props #(
	parameter integer WAKE_CYC = 20,
	parameter integer DEB_CYC  = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        card_present_in,
	input wire logic        status_led_n,
	input wire logic        host_wake_n,
	input wire logic        card_init_start,
	input wire logic        card_read_start,
	input wire logic        net_reg_req,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access taken, request writes and the two sequencing strobes.
	wire acc    = psel && penable && !pready;
	wire req_wr = acc && pwrite && paddr == 12'h014;
	wire rd_go  = req_wr && pwdata[2];
	wire rg_go  = req_wr && pwdata[3];
	wire wk_wr  = req_wr && (pwdata[0] || pwdata[1]);
	logic        sms_en_ff;  // Mirror of the SMS wake enable bit, as last written.
	// Follows control writes so the SMS gate can be checked from the ports.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sms_en_ff <= 1'b0;
		else if (acc && pwrite && paddr == 12'h000)
			sms_en_ff <= pwdata[2];
	logic [31:0] low_cnt_ff; // Cycles the wake output has been low so far.
	// Counts the wake pulse so its length can be compared on release.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			low_cnt_ff <= 32'h0;
		else if (host_wake_n)
			low_cnt_ff <= 32'h0;
		else
			low_cnt_ff <= low_cnt_ff + 32'h1;
	sequence ctrl_wr_s;
		acc && pwrite && paddr == 12'h000;
	endsequence
	sequence even_off_s;
		acc && pwrite && paddr == 12'h010 && pwdata == 32'h0;
	endsequence
	wake_len_a: assert property ($rose(host_wake_n) |-> low_cnt_ff == WAKE_CYC)
		else $error("wake pulse length wrong");
	wake_max_a: assert property (low_cnt_ff <= WAKE_CYC)
		else $error("wake pulse too long");
	wake_cause_a: assert property ($fell(host_wake_n) |-> $past(wk_wr) || $past(wk_wr, 2))
		else $error("wake pulse without request");
	sms_gate_a: assert property (req_wr && pwdata[0] && !pwdata[1] && !sms_en_ff |=> !$fell(host_wake_n))
		else $error("sms wake without enable");
	led_rf_a: assert property (ctrl_wr_s |=> ##1 status_led_n == !$past(pwdata[3], 2))
		else $error("led does not follow rf state");
	read_order_a: assert property (card_read_start |-> $past(rd_go) || $past(rd_go, 2))
		else $error("card read without init done");
	reg_order_a: assert property (net_reg_req |-> $past(rg_go) || $past(rg_go, 2))
		else $error("registration without read done");
	irq_mask_a: assert property (even_off_s |=> ##1 !irq)
		else $error("irq with all enables off");
	bus_wait_a: assert property (acc |=> pready ##1 !pready)
		else $error("pready not one cycle after access");
	bus_err_a: assert property (acc && paddr > 12'h014 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule // sdsw_props
bind sdsw_main sdsw_props #(.WAKE_CYC(WAKE_CYC), .DEB_CYC(DEB_CYC)) props_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .card_present_in, .status_led_n, .host_wake_n,
	.card_init_start, .card_read_start, .net_reg_req, .irq);
`default_nettype wire

// ==== sdsw_slot.sv ====
// Card slot switch model that drives the card-presence pin.
`timescale 1ns/1ps
`default_nettype none
module sdsw_slot (
	input  wire logic inserted,
	input  wire logic glitch,
	output wire logic card_present_in
);
	// The slot drives the pin high with a card in; glitch models contact bounce.
	assign card_present_in = inserted ^ glitch;
endmodule // sdsw_slot
`default_nettype wire

// ==== sdsw_tb.sv ====
// Self-checking bench for the card-detect and wake block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam integer WAKE = 20; // Shortened wake pulse.
	logic        pclk, presetn, psel, penable, pwrite, inserted, glitch;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready, pslverr, card_present_in, status_led_n, host_wake_n;
	wire         card_init_start, card_read_start, net_reg_req, irq;
	logic [64:0] exp_q[$]; // Expected notes: error flag, data mask, data.
	logic [64:0] e;
	int          failures, total_checks, low_run, last_low, n_init, n_read, n_reg, r;
	sdsw_main #(.WAKE_CYC(WAKE), .DEB_CYC(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .card_present_in, .status_led_n, .host_wake_n,
		.card_init_start, .card_read_start, .net_reg_req, .irq);
	sdsw_slot slot_u (.inserted, .glitch, .card_present_in);
	initial
	begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] want);
		total_checks++;
		if (seen !== want)
		begin
			failures++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// One APB transfer; the expected answer is noted before the request goes out.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [64:0] note);
		@(posedge pclk);
		exp_q.push_back(note);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, 65'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 32'h0, {a > 12'h014, 32'hFFFF_FFFF, x});
	endtask
	// Watches answers and strobes; takes the oldest note on every pready.
	always @(posedge pclk)
	begin
		if (pready === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(1, 0); // Answer with no request outstanding.
			else
			begin
				e = exp_q.pop_front();
				chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
			end
		end
		if (card_init_start === 1'b1) n_init++;
		if (card_read_start === 1'b1) n_read++;
		if (net_reg_req === 1'b1) n_reg++;
		if (host_wake_n === 1'b0)
			low_run++;
		else if (low_run > 0)
		begin
			last_low = low_run;
			low_run = 0;
		end
	end
	task automatic wrap_up();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog that cuts a hang short.
	initial
	begin
		repeat (6000) @(posedge pclk);
		failures++;
		wrap_up();
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, inserted, glitch} = '0;
		presetn = 0;
		void'($urandom(32'h9825));
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rd(12'h000, 32'h1);
		rd(12'h004, 32'h2);
		rd(12'h020, 32'h0);
		inserted <= 1;
		repeat (12) @(posedge pclk);
		rd(12'h004, 32'h5);
		wr(12'h014, 32'h4);
		rd(12'h004, 32'h9);
		wr(12'h014, 32'h8);
		repeat (3) @(posedge pclk);
		rd(12'h004, 32'h21);
		r = $urandom_range(2, 1);
		glitch <= 1;
		repeat (r) @(posedge pclk);
		glitch <= 0;
		repeat (12) @(posedge pclk);
		rd(12'h004, 32'h21);
		$display("insert test done");
		inserted <= 0;
		repeat (12) @(posedge pclk);
		rd(12'h004, 32'h2);
		rd(12'h008, 32'h3);
		chk(n_init, 1);
		chk(n_read, 1);
		chk(n_reg, 1);
		wr(12'h010, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1);
		wr(12'h010, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		wr(12'h00C, 32'h3);
		rd(12'h008, 32'h0);
		$display("removal and irq test done");
		wr(12'h000, 32'h3);
		repeat (12) @(posedge pclk);
		rd(12'h004, 32'h5);
		wr(12'h000, 32'h1);
		repeat (12) @(posedge pclk);
		wr(12'h000, 32'h0);
		inserted <= 1;
		repeat (12) @(posedge pclk);
		rd(12'h004, 32'h2);
		inserted <= 0;
		wr(12'h000, 32'h9);
		repeat (2) @(posedge pclk);
		chk(status_led_n, 0);
		wr(12'h000, 32'h1);
		repeat (2) @(posedge pclk);
		chk(status_led_n, 1);
		$display("polarity, hotplug and led tests done");
		last_low = 0;
		wr(12'h014, 32'h1);
		repeat (25) @(posedge pclk);
		chk(last_low, 0);
		wr(12'h000, 32'h5);
		for (int k = 0; k < 2; k++)
		begin
			last_low = 0;
			wr(12'h014, 32'h1 << k);
			wr(12'h014, 32'h3);
			apb(0, 12'h004, 32'h0, {1'b0, 32'h40, 32'h40});
			repeat (30) @(posedge pclk);
			chk(last_low, WAKE);
		end
		apb(0, 12'h008, 32'h0, {1'b0, 32'h4, 32'h4});
		$display("wake test done");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
